// ### icp_cfg.svh
`ifndef ICP_CFG_SVH
`define ICP_CFG_SVH
`define ICP_CLK_MHZ 50
`define ICP_SETTLE_US 100
`define ICP_SETTLE_CYC (`ICP_SETTLE_US * `ICP_CLK_MHZ)
`define ICP_STEP_NS 4000
`define ICP_STEP_CYC ((`ICP_STEP_NS * `ICP_CLK_MHZ) / 1000)
`define ICP_DIR_SETUP_CYC (`ICP_STEP_CYC / 4)
`define ICP_LOW_END_CYC ((`ICP_STEP_CYC * 3) / 4)
`define ICP_LOW_PCT 16'h0032
`define ICP_HIGH_PCT 16'h0046
`define ICP_HUNDRED 16'h0064
`define ICP_STEP8 8'h01
`define ICP_STEP6 8'h04
`define ICP_HALF_BIT 7
`define ICP_RES6_MASK 8'hfc
`define ICP_AMP_SET_RST 8'h80
`define ICP_OFF_CTRL 12'h000
`define ICP_OFF_STATUS 12'h004
`define ICP_OFF_IRQ_STAT 12'h008
`define ICP_OFF_IRQ_MASK 12'h00c
`define ICP_IRQ_W 3
`define ICP_IRQ_REACHED 0
`define ICP_IRQ_FAULT_SET 1
`define ICP_IRQ_FAULT_CLR 2
`endif

// ### icp_pkg.sv
`default_nettype none
package icp_pkg;
   typedef enum logic [1:0] {
      ICP_IDLE,
      ICP_SETTLE,
      ICP_SEARCH,
      ICP_TRACK
   } icp_state_type;
   typedef struct packed {
      logic res6;
      logic dir_mode;
   } icp_mode_type;
endpackage : icp_pkg
`default_nettype wire

// ### icp_step_if.sv
`timescale 1ns/1ps
`default_nettype none
interface icp_step_if;
   logic req;
   logic up;
   logic dir_mode;
   logic zero_after;
   logic busy;
   logic done;
   modport ctl (output req, output up, output dir_mode, output zero_after, input busy, input done);
   modport gen (input req, input up, input dir_mode, input zero_after, output busy, output done);
endinterface : icp_step_if
`default_nettype wire

// ### icp_step_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "icp_cfg.svh"
module icp_step_gen (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   icp_step_if.gen step,
   output logic port_a_o,
   output logic port_b_o,
   output logic port_c_o
);
   logic [7:0] cnt_q;
   logic busy_q;
   logic done_q;
   logic up_q;
   logic dm_q;
   logic zero_q;
   wire at_setup = busy_q && (cnt_q == 8'(`ICP_DIR_SETUP_CYC));
   wire at_rise = busy_q && (cnt_q == 8'(`ICP_LOW_END_CYC));
   wire at_last = busy_q && (cnt_q == 8'(`ICP_STEP_CYC - 1));

   assign step.busy = busy_q;
   assign step.done = done_q;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         up_q <= 1'b0;
         dm_q <= 1'b0;
         zero_q <= 1'b0;
         port_a_o <= 1'b1;
         port_b_o <= 1'b1;
         port_c_o <= 1'b0;
      end else if (!enable_i) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         port_a_o <= 1'b1;
         port_b_o <= 1'b1;
         port_c_o <= 1'b0;
      end else begin
         done_q <= at_rise;
         if (!busy_q && step.req) begin
            busy_q <= 1'b1;
            cnt_q <= 8'h00;
            up_q <= step.up;
            dm_q <= step.dir_mode;
            zero_q <= step.zero_after;
            // direction settles a quarter period ahead of the falling edge
            if (step.dir_mode) begin
               port_b_o <= ~step.up;
            end
         end else if (busy_q) begin
            cnt_q <= cnt_q + 8'h01;
         end
         if (at_setup) begin
            // with dir_mode low only one line ever falls, so up and down never overlap
            if (dm_q || up_q) begin
               port_a_o <= 1'b0;
            end else begin
               port_b_o <= 1'b0;
            end
            port_c_o <= ~zero_q;
         end
         if (at_rise) begin
            port_a_o <= 1'b1;
            if (!dm_q) begin
               port_b_o <= 1'b1;
            end
         end
         if (at_last) begin
            busy_q <= 1'b0;
         end
      end
   end
endmodule : icp_step_gen
`default_nettype wire

// ### icp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "icp_cfg.svh"
module icp_top #(
   parameter int unsigned SETTLE_CYC = `ICP_SETTLE_CYC
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_n_input_i,
   input wire logic config_input_one_i,
   input wire logic config_input_two_i,
   input wire logic config_input_three_i,
   input wire logic [7:0] angle_i,
   input wire logic [7:0] amplitude_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic up_count_pulse_n_o,
   output logic down_count_pulse_n_o,
   output logic zero_clear_n_o,
   output logic amplitude_fault_n_o,
   output logic irq_o
);
   import icp_pkg::*;

   // next position after one step at the chosen resolution
   function automatic logic [7:0] step_pos(input logic [7:0] p, input logic up, input logic res6);
      logic [7:0] inc;
      inc = res6 ? `ICP_STEP6 : `ICP_STEP8;
      step_pos = up ? (p + inc) : (p - inc);
   endfunction : step_pos

   // percentage of the amplitude set point, widened to avoid overflow
   function automatic logic [15:0] pct_of(input logic [7:0] v, input logic [15:0] pct);
      pct_of = 16'(v) * pct;
   endfunction : pct_of

   // pins are asynchronous to ref_clk_i
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   wire en_n_s = pin_s2_q[0];
   wire config_input_one_s = pin_s2_q[1];
   wire config_input_two_s = pin_s2_q[2];
   wire config_input_three_s = pin_s2_q[3];
   wire enabled = ~en_n_s;

   icp_state_type state_q;
   icp_state_type state_d;
   icp_mode_type mode_q;
   logic [7:0] pos_q;
   logic req_q;
   logic fault_q;
   logic [12:0] settle_q;
   logic [7:0] amp_set_q;
   logic [`ICP_IRQ_W-1:0] irq_stat_q;
   logic [`ICP_IRQ_W-1:0] irq_mask_q;
   logic step_a;
   logic step_b;
   logic step_c;

   icp_step_if step_bus ();

   // target angle truncated to the chosen resolution
   wire [7:0] target = mode_q.res6 ? (angle_i & `ICP_RES6_MASK) : angle_i;
   wire [7:0] diff = target - pos_q;
   // shortest way round: below half a period count up, else down
   wire go_up = ~diff[`ICP_HALF_BIT];
   wire at_target = (diff == 8'h00);
   wire moving = (state_q == ICP_SEARCH) || (state_q == ICP_TRACK);
   wire issue = moving && !at_target && !step_bus.busy && !req_q;
   wire [7:0] pos_after = step_pos(pos_q, go_up, mode_q.res6);
   wire [7:0] pos_done = step_pos(pos_q, step_bus.up, mode_q.res6);

   wire amp_low = pct_of(amplitude_i, `ICP_HUNDRED) < pct_of(amp_set_q, `ICP_LOW_PCT);
   wire amp_high = pct_of(amplitude_i, `ICP_HUNDRED) > pct_of(amp_set_q, `ICP_HIGH_PCT);
   wire settled = (settle_q >= 13'(SETTLE_CYC)) && !fault_q;
   wire reach_evt = (state_q == ICP_SEARCH) && at_target && !req_q && !step_bus.busy;
   wire fault_set_evt = !fault_q && amp_low && enabled;
   wire fault_clr_evt = fault_q && amp_high && enabled;
   wire [`ICP_IRQ_W-1:0] irq_evt = {fault_clr_evt, fault_set_evt, reach_evt};

   assign step_bus.req = req_q;
   assign step_bus.dir_mode = mode_q.dir_mode;

   icp_step_gen u_step (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(enabled),
      .step(step_bus.gen),
      .port_a_o(step_a),
      .port_b_o(step_b),
      .port_c_o(step_c)
   );

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_s1_q <= 4'hf;
         pin_s2_q <= 4'hf;
      end else begin
         pin_s1_q <= {config_input_three_i, config_input_two_i, config_input_one_i, enable_n_input_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   // mode only changes while disabled, so a count never switches style midway
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_q <= '0;
      end else if (!enabled && config_input_one_s) begin
         mode_q.res6 <= config_input_two_s;
         mode_q.dir_mode <= config_input_three_s;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         ICP_IDLE: begin
            if (enabled) begin
               state_d = ICP_SETTLE;
            end
         end
         ICP_SETTLE: begin
            if (settled) begin
               state_d = ICP_SEARCH;
            end
         end
         ICP_SEARCH: begin
            if (reach_evt) begin
               state_d = ICP_TRACK;
            end
         end
         ICP_TRACK: begin
            state_d = ICP_TRACK;
         end
         default: begin
            state_d = ICP_IDLE;
         end
      endcase
      if (!enabled) begin
         state_d = ICP_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ICP_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // settling counter saturates; the search also waits for the fault to clear
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         settle_q <= 13'h0000;
      end else if (state_q != ICP_SETTLE) begin
         settle_q <= 13'h0000;
      end else if (settle_q < 13'(SETTLE_CYC)) begin
         settle_q <= settle_q + 13'h0001;
      end
   end

   // position always restarts at zero, one step per 4 us at most
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pos_q <= 8'h00;
         req_q <= 1'b0;
         step_bus.up <= 1'b0;
         step_bus.zero_after <= 1'b0;
      end else if (!enabled) begin
         pos_q <= 8'h00;
         req_q <= 1'b0;
      end else begin
         req_q <= issue;
         if (issue) begin
            step_bus.up <= go_up;
            step_bus.zero_after <= (pos_after == 8'h00);
         end
         if (step_bus.done) begin
            pos_q <= pos_done;
         end
      end
   end

   // hysteresis between the 50 and 70 percent thresholds
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fault_q <= 1'b1;
      end else if (!enabled) begin
         fault_q <= 1'b1;
      end else if (fault_set_evt) begin
         fault_q <= 1'b1;
      end else if (fault_clr_evt) begin
         fault_q <= 1'b0;
      end
   end

   // count and clear pins are driven from the step generator flops through one more flop, the fault pin from fault_q
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         up_count_pulse_n_o <= 1'b1;
         down_count_pulse_n_o <= 1'b1;
         zero_clear_n_o <= 1'b0;
         amplitude_fault_n_o <= 1'b0;
      end else begin
         up_count_pulse_n_o <= step_a;
         down_count_pulse_n_o <= step_b;
         zero_clear_n_o <= step_c;
         amplitude_fault_n_o <= ~fault_q;
      end
   end

   // register bus: one wait state on every access
   wire apb_acc = psel && penable && !pready;
   wire sel_ctrl = (paddr == `ICP_OFF_CTRL);
   wire sel_stat = (paddr == `ICP_OFF_STATUS);
   wire sel_istat = (paddr == `ICP_OFF_IRQ_STAT);
   wire sel_imask = (paddr == `ICP_OFF_IRQ_MASK);
   wire mapped = sel_ctrl || sel_stat || sel_istat || sel_imask;
   // writes land on the edge where the master sees pready, never earlier
   wire wr = psel && penable && pready && pwrite && mapped;
   wire [`ICP_IRQ_W-1:0] w1c = (wr && sel_istat) ? pwdata[`ICP_IRQ_W-1:0] : '0;
   wire [31:0] status_word = {16'h0000, pos_q, 3'b000, mode_q.res6, mode_q.dir_mode, fault_q,
                              state_q};
   wire [31:0] rd_word = sel_ctrl ? {24'h000000, amp_set_q} :
                         sel_stat ? status_word :
                         sel_istat ? {29'h00000000, irq_stat_q} :
                         sel_imask ? {29'h00000000, irq_mask_q} : 32'h00000000;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apb_acc;
         pslverr <= apb_acc && !mapped;
         prdata <= (apb_acc && !pwrite) ? rd_word : 32'h00000000;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         amp_set_q <= `ICP_AMP_SET_RST;
         irq_mask_q <= '0;
      end else begin
         if (wr && sel_ctrl) begin
            amp_set_q <= pwdata[7:0];
         end
         if (wr && sel_imask) begin
            irq_mask_q <= pwdata[`ICP_IRQ_W-1:0];
         end
      end
   end

   // a new event wins over a clear landing in the same cycle
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_stat_q <= '0;
         irq_o <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~w1c) | irq_evt;
         irq_o <= |(((irq_stat_q & ~w1c) | irq_evt) & irq_mask_q);
      end
   end
endmodule : icp_top
`default_nettype wire

// ### icp_ext_counter.sv
`timescale 1ns/1ps
`default_nettype none
module icp_ext_counter (
   input wire logic dir_mode_i,
   input wire logic a_i,
   input wire logic b_i,
   input wire logic clr_n_i,
   output logic [7:0] count_o
);
   logic [7:0] up_q;
   logic [7:0] dd_q;
   logic [7:0] dn_q;
   // one event count per pin edge, so a level change on the other pin never steps it
   always @(posedge a_i or negedge clr_n_i) begin
      if (!clr_n_i) begin
         up_q <= 8'h00;
         dd_q <= 8'h00;
      end else if (dir_mode_i) begin
         if (b_i) dd_q <= dd_q + 8'h01;
         else up_q <= up_q + 8'h01;
      end else if (b_i) begin
         up_q <= up_q + 8'h01;
      end
   end
   always @(posedge b_i or negedge clr_n_i) begin
      if (!clr_n_i) dn_q <= 8'h00;
      else if (!dir_mode_i && a_i) dn_q <= dn_q + 8'h01;
   end
   // wraps like two cascaded nibble stages
   assign count_o = up_q - dn_q - dd_q;
endmodule : icp_ext_counter
`default_nettype wire

// ### icp_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "icp_cfg.svh"
module icp_checker (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_n_input_i,
   input wire logic config_input_one_i,
   input wire logic config_input_three_i,
   input wire logic [7:0] amplitude_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic up_count_pulse_n_o,
   input wire logic down_count_pulse_n_o,
   input wire logic zero_clear_n_o,
   input wire logic amplitude_fault_n_o
);
   logic dir_q;
   logic [7:0] set_q;
   logic [7:0] lo_q;
   logic [7:0] hi_q;
   logic [7:0] en_q;
   wire logic a = up_count_pulse_n_o;
   wire logic b = down_count_pulse_n_o;
   // mode checks wait out the enable synchroniser lag
   wire logic on = en_q > 8'h06;
   wire logic sep = on && !dir_q;
   wire logic lo_amp = {amplitude_i, 1'b0} < {1'b0, set_q};
   wire logic hi_amp = ({4'h0, amplitude_i} * 12'h00a) > ({4'h0, set_q} * 12'h007);
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dir_q <= 1'b0;
         set_q <= `ICP_AMP_SET_RST;
         lo_q <= 8'h00;
         hi_q <= 8'h00;
         en_q <= 8'h00;
      end else begin
         if (enable_n_input_i && config_input_one_i) dir_q <= config_input_three_i;
         if (psel && penable && pready && pwrite && paddr == `ICP_OFF_CTRL) set_q <= pwdata[7:0];
         lo_q <= a ? 8'h00 : lo_q + 8'h01;
         hi_q <= !a ? 8'h00 : hi_q + {7'h00, hi_q != 8'hff};
         en_q <= enable_n_input_i ? 8'h00 : en_q + {7'h00, en_q != 8'hff};
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   reset_out_a: assert property (disable iff (1'b0) sys_rst_i |-> a && b && !zero_clear_n_o && !amplitude_fault_n_o)
      else $error("outputs not at reset level");
   idle_down_a: assert property (sep && $fell(a) |-> b [*8])
      else $error("down line not high during up pulse");
   no_overlap_a: assert property (sep && $fell(b) |-> a [*8])
      else $error("up line not high during down pulse");
   dir_hold_a: assert property (on && dir_q && !a |-> $stable(b))
      else $error("direction moved during step pulse");
   clear_sync_a: assert property (on && $changed(zero_clear_n_o) |-> !a || (!dir_q && !b))
      else $error("clear changed while count line high");
   pulse_len_a: assert property ($rose(a) |-> lo_q == 8'h64)
      else $error("step pulse low time wrong");
   step_gap_a: assert property ($fell(a) |-> hi_q >= 8'h64)
      else $error("steps too close");
   fault_low_a: assert property (lo_amp [*6] |-> !amplitude_fault_n_o)
      else $error("fault not flagged at low amplitude");
   fault_high_a: assert property (en_q == 8'hff && hi_amp [*6] |-> amplitude_fault_n_o)
      else $error("fault not cleared at high amplitude");
   cover property (sep && $rose(a));
   cover property (on && dir_q && $rose(a) && b);
   cover property (en_q == 8'hff && $fell(amplitude_fault_n_o));
endmodule : icp_checker
bind icp_top icp_checker chk (.ref_clk_i, .sys_rst_i, .enable_n_input_i, .config_input_one_i, .config_input_three_i,
   .amplitude_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .up_count_pulse_n_o, .down_count_pulse_n_o,
   .zero_clear_n_o, .amplitude_fault_n_o);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "icp_cfg.svh"
module tb_top;
   logic clk, rst, en_n, config_input_one, config_input_two, config_input_three, psel, penable, pwrite, perr;
   logic a, b, c, d, irq, pready, pslverr;
   logic [7:0] angle, amp, cnt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_total, n_checks, cyc;
   icp_top #(.SETTLE_CYC(20)) dut (.ref_clk_i(clk), .sys_rst_i(rst), .enable_n_input_i(en_n),
      .config_input_one_i(config_input_one), .config_input_two_i(config_input_two), .config_input_three_i(config_input_three), .angle_i(angle),
      .amplitude_i(amp), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .up_count_pulse_n_o(a), .down_count_pulse_n_o(b),
      .zero_clear_n_o(c), .amplitude_fault_n_o(d), .irq_o(irq));
   icp_ext_counter ext (.dir_mode_i(config_input_three), .a_i(a), .b_i(b), .clr_n_i(c), .count_o(cnt));
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // k steps: last count edge lands within k step periods plus settling
   task automatic wait_cnt(input logic [7:0] e, input int k);
      int n;
      n = 0;
      while (cnt !== e && n < 30000) begin
         @(posedge clk);
         n++;
      end
      // a step onto zero clears the counter at its falling edge, 100 cycles early
      chk({7'h00, n >= (k - 1) * 200 + (e == 8'h00 ? 50 : 150) && n <= k * 202 + 100}, 8'h01);
      repeat (400) @(posedge clk);
      chk(cnt, e);
   endtask : wait_cnt
   task automatic run(input logic r6, input logic dm, input logic [7:0] ang, input logic [7:0] e, input int k);
      en_n <= 1'b1;
      repeat (8) @(posedge clk);
      config_input_two <= r6;
      config_input_three <= dm;
      angle <= ang;
      repeat (8) @(posedge clk);
      en_n <= 1'b0;
      wait_cnt(e, k);
   endtask : run
   task automatic seek(input logic [7:0] ang, input logic [7:0] e, input int k);
      angle <= ang;
      wait_cnt(e, k);
   endtask : seek
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      rst = 1'b0;
      en_n = 1'b1;
      config_input_one = 1'b1;
      config_input_two = 1'b0;
      config_input_three = 1'b0;
      angle = 8'h00;
      amp = 8'hff;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      // a real reset edge before the first clock, so no output is unknown at it
      #1 rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({4'h0, a, b, c, d}, 8'h0c);
      apb(1'b0, `ICP_OFF_CTRL, 32'h0);
      chk(q[7:0], 8'h80);
      apb(1'b0, `ICP_OFF_IRQ_MASK, 32'h0);
      chk(q[7:0], 8'h00);
      apb(1'b0, 12'h010, 32'h0);
      chk({perr, q[6:0]}, 8'h80);
      run(1'b0, 1'b0, 8'h05, 8'h05, 5);
      chk({7'h00, c}, 8'h01);
      apb(1'b0, `ICP_OFF_IRQ_STAT, 32'h0);
      chk({5'h00, q[2:0]}, 8'h05);
      apb(1'b0, `ICP_OFF_STATUS, 32'h0);
      chk(q[15:8], 8'h05);
      seek(8'h02, 8'h02, 3);
      seek(8'h00, 8'h00, 2);
      chk({7'h00, c}, 8'h00);
      run(1'b0, 1'b1, 8'hc8, 8'hc8, 56);
      run(1'b1, 1'b0, 8'h80, 8'he0, 32);
      apb(1'b0, `ICP_OFF_STATUS, 32'h0);
      chk(q[15:8], 8'h80);
      apb(1'b1, `ICP_OFF_IRQ_STAT, 32'h7);
      apb(1'b1, `ICP_OFF_IRQ_MASK, 32'h2);
      amp <= 8'h30;
      repeat (10) @(posedge clk);
      chk({6'h00, d, irq}, 8'h01);
      apb(1'b1, `ICP_OFF_IRQ_MASK, 32'h0);
      repeat (3) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      // lower set point puts the same amplitude above the release level
      apb(1'b1, `ICP_OFF_CTRL, 32'h40);
      repeat (10) @(posedge clk);
      chk({7'h00, d}, 8'h01);
      apb(1'b0, `ICP_OFF_IRQ_STAT, 32'h0);
      chk({6'h00, q[2:1]}, 8'h03);
      apb(1'b1, `ICP_OFF_IRQ_STAT, 32'h7);
      apb(1'b0, `ICP_OFF_IRQ_STAT, 32'h0);
      chk({6'h00, q[2:1]}, 8'h00);
      // config one low: mode pins ignored even while disabled
      en_n <= 1'b1;
      config_input_one <= 1'b0;
      config_input_two <= 1'b0;
      config_input_three <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b0, `ICP_OFF_STATUS, 32'h0);
      chk({6'h00, q[4:3]}, 8'h02);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
